/* hw/iwm_move_unit.sv */
// execution unit for inverted, indirect and indirect inverted moves
// assumes a device memory answering each read strobe one cycle later
// and a one-cycle scan strobe from the program sequencer
//
// Chosen here: the plain strobed port and the address map.
`default_nettype none

module iwm_move_unit #(
    parameter logic [15:0] SYS_PROG_VERSION = 16'h00c8
) (
    // clock and reset
    input  wire logic                  mclk,
    input  wire logic                  rst_b,
    // register port
    input  wire logic [3:0]            reg_addr,
    input  wire logic [31:0]           reg_wdata,
    input  wire logic                  reg_wr,
    input  wire logic                  reg_rd,
    output logic      [31:0]           reg_rdata,
    // scan trigger
    input  wire logic                  exec_en,
    input  wire logic                  scan_pulse,
    // device memory
    output iwm_pkg::iwm_mem_req_type   mem,
    input  wire logic [15:0]           mem_rdata,
    // status
    output logic                       exec_error_flag,
    output logic                       err_led,
    output logic                       busy,
    output logic                       irq
);
    typedef enum logic [3:0] {
        ST_IDLE, ST_SOFS, ST_SOFS_W, ST_DOFS, ST_DOFS_W, ST_CHECK,
        ST_LOAD, ST_RD, ST_RD_W, ST_FCHK, ST_WR, ST_NEXT, ST_DONE, ST_ERR
    } iwm_state_type;

    logic                    rst_s1_q, rst_n_s;
    logic [5:0]              ctrl_q, ctrl_d;
    iwm_pkg::iwm_operand_type sb_q, sb_d, so_q, so_d, db_q, db_d, do_q, do_d;
    logic [31:0]             const_q, const_d, rdata_d;
    logic                    errf_q, errf_d;
    logic [1:0]              ist_q, ist_d, imsk_q, imsk_d;
    iwm_state_type           state_q, state_d;
    logic [6:0]              step_q, step_d;
    logic                    half_q, half_d;
    logic [15:0]             sofs_q, sofs_d, dofs_q, dofs_d;
    logic [31:0]             data_q, data_d;
    iwm_pkg::iwm_mem_req_type mem_q, mem_d;
    logic [1:0]              opc, dt;
    logic                    dword, inv, use_so, use_do, fw_ok;
    logic                    s_bit, d_bit, s_ok, d_ok, bad;
    logic [6:0]              nsteps, s_step, d_step;
    logic [15:0]             s_eff, d_eff;
    logic                    ev_done, ev_err;

    // reset release through two stages; the async edge only forces zero
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            rst_s1_q <= 1'b0;
            rst_n_s  <= 1'b0;
        end else begin
            rst_s1_q <= 1'b1;
            rst_n_s  <= rst_s1_q;
        end
    end

    function automatic iwm_pkg::iwm_operand_type to_opd(input logic [31:0] w);
        to_opd.rep   = w[iwm_pkg::OPD_REP_LSB +: 7];
        to_opd.dev   = w[iwm_pkg::OPD_DEV_LSB +: 4];
        to_opd.index = w[15:0];
    endfunction : to_opd

    function automatic logic [31:0] from_opd(input iwm_pkg::iwm_operand_type o);
        from_opd = {1'b0, o.rep, 4'h0, o.dev, o.index};
    endfunction : from_opd

    function automatic logic [6:0] min_step(input logic [6:0] r, input logic [6:0] s);
        min_step = (iwm_pkg::rep1(r) - 7'h01 < s) ? iwm_pkg::rep1(r) - 7'h01 : s;
    endfunction : min_step

    // decode of control and operand fields
    always_comb begin
        opc    = ctrl_q[iwm_pkg::CTRL_OPC_LSB +: 2];
        dt     = ctrl_q[iwm_pkg::CTRL_DT_LSB +: 2];
        dword  = (dt != iwm_pkg::DT_WORD);
        inv    = (opc != iwm_pkg::OPC_ICOPY);
        // offsets optional, never on plain inverted copy
        use_so = ctrl_q[iwm_pkg::CTRL_SOP_BIT] && (opc != iwm_pkg::OPC_COPY_INV);
        use_do = ctrl_q[iwm_pkg::CTRL_DOP_BIT] && (opc != iwm_pkg::OPC_COPY_INV);
        fw_ok  = (SYS_PROG_VERSION >= iwm_pkg::FW_FLOAT_MIN);
        s_bit  = iwm_pkg::is_bit_dev(sb_q.dev);
        d_bit  = iwm_pkg::is_bit_dev(db_q.dev);
        nsteps = (iwm_pkg::rep1(sb_q.rep) > iwm_pkg::rep1(db_q.rep)) ?
                 iwm_pkg::rep1(sb_q.rep) : iwm_pkg::rep1(db_q.rep);
        // check pass uses the last step: ranges only grow with the step
        s_step = min_step(sb_q.rep, (state_q == ST_CHECK) ? nsteps - 7'h01 : step_q);
        d_step = min_step(db_q.rep, (state_q == ST_CHECK) ? nsteps - 7'h01 : step_q);
        ev_done = (state_q == ST_DONE);
        ev_err  = (state_q == ST_ERR);
    end

    iwm_addr_chk u_src_chk (
        .dev   (sb_q.dev),
        .base  (sb_q.index),
        .ofs   (sofs_q),
        .step  (s_step),
        .dword (dword),
        .eff   (s_eff),
        .ok    (s_ok)
    );

    iwm_addr_chk u_dst_chk (
        .dev   (db_q.dev),
        .base  (db_q.index),
        .ofs   (dofs_q),
        .step  (d_step),
        .dword (dword),
        .eff   (d_eff),
        .ok    (d_ok)
    );

    // operand rule checks evaluated before anything is written
    always_comb begin
        bad = (opc == 2'h3) || (dt == 2'h3) || !s_ok || !d_ok;
        // float only on indirect copy between data registers
        bad = bad || ((dt == iwm_pkg::DT_FLOAT) && (!fw_ok ||
              (opc != iwm_pkg::OPC_ICOPY) || (sb_q.dev != iwm_pkg::DEV_DATA) ||
              (db_q.dev != iwm_pkg::DEV_DATA)));
        // repeat range and no constant offsets
        bad = bad || (sb_q.rep > iwm_pkg::REP_MAX) || (db_q.rep > iwm_pkg::REP_MAX);
        bad = bad || (use_so && (so_q.dev >= iwm_pkg::DEV_CONST));
        bad = bad || (use_do && (do_q.dev >= iwm_pkg::DEV_CONST));
        // constant source only for plain inverted copy
        bad = bad || ((sb_q.dev == iwm_pkg::DEV_CONST) && (opc != iwm_pkg::OPC_COPY_INV));
        // no inputs, special relays or constants as destination
        bad = bad || (db_q.dev == iwm_pkg::DEV_IN) || (db_q.dev == iwm_pkg::DEV_SPECIAL) ||
              (db_q.dev >= iwm_pkg::DEV_CONST);
    end

    // move sequencer
    always_comb begin
        state_d = state_q;
        step_d  = step_q;
        half_d  = half_q;
        sofs_d  = sofs_q;
        dofs_d  = dofs_q;
        data_d  = data_q;
        mem_d   = mem_q;
        mem_d.rd = 1'b0;
        mem_d.wr = 1'b0;
        case (state_q)
            ST_IDLE: if (scan_pulse && exec_en) begin
                step_d  = 7'h00;
                half_d  = 1'b0;
                sofs_d  = 16'h0000;
                dofs_d  = 16'h0000;
                state_d = ST_SOFS;
            end
            // offsets on timers or counters read current value
            ST_SOFS: begin
                mem_d.rd     = use_so;
                mem_d.preset = 1'b0;
                mem_d.dev    = so_q.dev;
                mem_d.addr   = so_q.index;
                state_d      = use_so ? ST_SOFS_W : ST_DOFS;
            end
            // answer stands the cycle after the strobe, so wait that cycle out
            ST_SOFS_W: if (!mem_q.rd) begin
                sofs_d  = mem_rdata;
                state_d = ST_DOFS;
            end
            ST_DOFS: begin
                mem_d.rd     = use_do;
                mem_d.preset = 1'b0;
                mem_d.dev    = do_q.dev;
                mem_d.addr   = do_q.index;
                state_d      = use_do ? ST_DOFS_W : ST_CHECK;
            end
            ST_DOFS_W: if (!mem_q.rd) begin
                dofs_d  = mem_rdata;
                state_d = ST_CHECK;
            end
            ST_CHECK: state_d = bad ? ST_ERR : ST_LOAD;
            // constant becomes the binary source value
            ST_LOAD: begin
                half_d = 1'b0;
                if (sb_q.dev == iwm_pkg::DEV_CONST) begin
                    data_d  = dword ? const_q : {16'h0000, const_q[15:0]};
                    state_d = ST_FCHK;
                end else begin
                    state_d = ST_RD;
                end
            end
            ST_RD: begin
                mem_d.rd     = 1'b1;
                mem_d.preset = 1'b0;
                mem_d.dev    = sb_q.dev;
                mem_d.addr   = s_bit ? s_eff + {11'h000, half_q, 4'h0}
                                     : s_eff + {15'h0000, half_q};
                state_d      = ST_RD_W;
            end
            ST_RD_W: if (!mem_q.rd) begin
                if (iwm_pkg::upper_half(half_q, s_bit, dword)) begin
                    data_d[31:16] = mem_rdata;
                end else begin
                    data_d[15:0] = mem_rdata;
                end
                if (dword && !half_q) begin
                    half_d  = 1'b1;
                    state_d = ST_RD;
                end else begin
                    state_d = ST_FCHK;
                end
            end
            // abnormal float is not moved; complement on inverted ops
            ST_FCHK: begin
                half_d = 1'b0;
                if ((dt == iwm_pkg::DT_FLOAT) && !iwm_pkg::float_normal(data_q)) begin
                    state_d = ST_ERR;
                end else begin
                    data_d  = inv ? ~data_q : data_q;
                    state_d = ST_WR;
                end
            end
            // write to destination, timers and counters take preset
            ST_WR: begin
                mem_d.wr     = 1'b1;
                mem_d.preset = (db_q.dev == iwm_pkg::DEV_TIMER) ||
                               (db_q.dev == iwm_pkg::DEV_COUNTER);
                mem_d.dev    = db_q.dev;
                mem_d.addr   = d_bit ? d_eff + {11'h000, half_q, 4'h0}
                                     : d_eff + {15'h0000, half_q};
                mem_d.wdata  = iwm_pkg::upper_half(half_q, d_bit, dword) ?
                               data_q[31:16] : data_q[15:0];
                half_d       = 1'b1;
                state_d      = (dword && !half_q) ? ST_WR : ST_NEXT;
            end
            ST_NEXT: if (step_q == nsteps - 7'h01) begin
                state_d = ST_DONE;
            end else begin
                step_d  = step_q + 7'h01;
                state_d = ST_LOAD;
            end
            ST_DONE: state_d = ST_IDLE;
            ST_ERR:  state_d = ST_IDLE;
            default: state_d = ST_IDLE;
        endcase
    end

    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            state_q <= ST_IDLE;
            step_q  <= 7'h00;
            half_q  <= 1'b0;
            sofs_q  <= 16'h0000;
            dofs_q  <= 16'h0000;
            data_q  <= 32'h0000_0000;
            mem_q   <= '0;
        end else begin
            state_q <= state_d;
            step_q  <= step_d;
            half_q  <= half_d;
            sofs_q  <= sofs_d;
            dofs_q  <= dofs_d;
            data_q  <= data_d;
            mem_q   <= mem_d;
        end
    end

    // register file; operand writes ignored while a move runs
    always_comb begin
        ctrl_d  = ctrl_q;
        sb_d    = sb_q;
        so_d    = so_q;
        db_d    = db_q;
        do_d    = do_q;
        const_d = const_q;
        imsk_d  = imsk_q;
        errf_d  = errf_q;
        ist_d   = ist_q;
        rdata_d = 32'h0000_0000;
        if (reg_wr && (state_q == ST_IDLE)) begin
            case (reg_addr)
                iwm_pkg::REG_CTRL:     ctrl_d  = reg_wdata[5:0];
                iwm_pkg::REG_SRC_BASE: sb_d    = to_opd(reg_wdata);
                iwm_pkg::REG_SRC_OFS:  so_d    = to_opd(reg_wdata);
                iwm_pkg::REG_DST_BASE: db_d    = to_opd(reg_wdata);
                iwm_pkg::REG_DST_OFS:  do_d    = to_opd(reg_wdata);
                iwm_pkg::REG_CONST:    const_d = reg_wdata;
                default: ;
            endcase
        end
        // write-one-to-clear flags; a same-cycle event wins
        if (reg_wr && (reg_addr == iwm_pkg::REG_STATUS) && reg_wdata[iwm_pkg::ST_ERR_BIT]) begin
            errf_d = 1'b0;
        end
        if (reg_wr && (reg_addr == iwm_pkg::REG_INT_STAT)) begin
            ist_d = ist_q & ~reg_wdata[1:0];
        end
        if (reg_wr && (reg_addr == iwm_pkg::REG_INT_MASK)) begin
            imsk_d = reg_wdata[1:0];
        end
        if (ev_err) begin
            errf_d = 1'b1;
        end
        ist_d = ist_d | {ev_err, ev_done};
        if (reg_rd) begin
            case (reg_addr)
                iwm_pkg::REG_CTRL:     rdata_d = {26'h0000000, ctrl_q};
                iwm_pkg::REG_SRC_BASE: rdata_d = from_opd(sb_q);
                iwm_pkg::REG_SRC_OFS:  rdata_d = from_opd(so_q);
                iwm_pkg::REG_DST_BASE: rdata_d = from_opd(db_q);
                iwm_pkg::REG_DST_OFS:  rdata_d = from_opd(do_q);
                iwm_pkg::REG_CONST:    rdata_d = const_q;
                iwm_pkg::REG_STATUS:   rdata_d = {30'h0, errf_q, state_q != ST_IDLE};
                iwm_pkg::REG_INT_STAT: rdata_d = {30'h0, ist_q};
                iwm_pkg::REG_INT_MASK: rdata_d = {30'h0, imsk_q};
                default:               rdata_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge mclk or negedge rst_n_s) begin
        if (!rst_n_s) begin
            ctrl_q    <= iwm_pkg::RST_CTRL;
            sb_q      <= '0;
            so_q      <= '0;
            db_q      <= '0;
            do_q      <= '0;
            const_q   <= iwm_pkg::RST_WORD;
            errf_q    <= 1'b0;
            ist_q     <= iwm_pkg::RST_INT;
            imsk_q    <= iwm_pkg::RST_INT;
            reg_rdata <= iwm_pkg::RST_WORD;
        end else begin
            ctrl_q    <= ctrl_d;
            sb_q      <= sb_d;
            so_q      <= so_d;
            db_q      <= db_d;
            do_q      <= do_d;
            const_q   <= const_d;
            errf_q    <= errf_d;
            ist_q     <= ist_d;
            imsk_q    <= imsk_d;
            reg_rdata <= rdata_d;
        end
    end

    // outputs
    assign mem             = mem_q;
    assign exec_error_flag = errf_q;
    assign err_led         = errf_q;
    assign busy            = (state_q != ST_IDLE);
    assign irq             = |(ist_q & imsk_q);

    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_n_s);

    a_start_when_enabled: assert property (
        (state_q == ST_IDLE && scan_pulse && exec_en) |=> busy ##1 (state_q == ST_SOFS_W ||
        state_q == ST_DOFS || state_q == ST_DOFS_W || state_q == ST_CHECK))
        else $error("enabled scan did not start a move");
    a_idle_when_disabled: assert property (
        (state_q == ST_IDLE && !exec_en) |=> !busy && !mem.wr)
        else $error("move ran with enable off");
    a_error_sets_flag: assert property (
        ev_err |=> exec_error_flag && err_led && ist_q[iwm_pkg::INT_ERR_BIT])
        else $error("execution error flag not raised");
    a_float_data_only: assert property (
        (state_q == ST_CHECK && dt == iwm_pkg::DT_FLOAT && sb_q.dev != iwm_pkg::DEV_DATA)
        |=> state_q == ST_ERR)
        else $error("float move accepted non data register");
    a_error_no_write: assert property (
        (state_q == ST_CHECK && bad) |=> !mem.wr [*3])
        else $error("destination written after operand error");
    a_repeat_limit: assert property (
        (state_q == ST_CHECK && (sb_q.rep > iwm_pkg::REP_MAX || db_q.rep > iwm_pkg::REP_MAX))
        |=> state_q == ST_ERR)
        else $error("repeat count above limit accepted");
    a_special_dest: assert property (
        (state_q == ST_CHECK && db_q.dev == iwm_pkg::DEV_SPECIAL) |=> state_q == ST_ERR)
        else $error("special relay accepted as destination");
    a_inverted_data: assert property (
        (state_q == ST_FCHK && inv && $past(state_q) != ST_FCHK && dt != iwm_pkg::DT_FLOAT)
        |=> data_q == ~$past(data_q))
        else $error("inverted move did not complement data");
endmodule : iwm_move_unit

`default_nettype wire

/* hw/iwm_addr_chk.sv */
// shared constants and types of the indirect word move unit, plus its
// address former; assumes a word-wide device memory outside the unit
`default_nettype none

package iwm_pkg;
    // device codes as software writes them into operand registers
    localparam logic [3:0] DEV_IN      = 4'h0;
    localparam logic [3:0] DEV_OUT     = 4'h1;
    localparam logic [3:0] DEV_RELAY   = 4'h2;
    localparam logic [3:0] DEV_SHIFT   = 4'h3;
    localparam logic [3:0] DEV_TIMER   = 4'h4;
    localparam logic [3:0] DEV_COUNTER = 4'h5;
    localparam logic [3:0] DEV_DATA    = 4'h6;
    localparam logic [3:0] DEV_SPECIAL = 4'h7;
    localparam logic [3:0] DEV_CONST   = 4'h8;
    // highest index per device (bit index for bit devices)
    localparam logic [15:0] MAX_IO      = 16'h01ff;
    localparam logic [15:0] MAX_RELAY   = 16'h09fd;
    localparam logic [15:0] MAX_SMALL   = 16'h00ff;
    localparam logic [15:0] MAX_DATA    = 16'h07ff;
    localparam logic [6:0]  REP_MAX     = 7'h63;
    localparam logic [15:0] FW_FLOAT_MIN = 16'h00c8;
    // register offsets
    localparam logic [3:0] REG_CTRL     = 4'h0;
    localparam logic [3:0] REG_SRC_BASE = 4'h1;
    localparam logic [3:0] REG_SRC_OFS  = 4'h2;
    localparam logic [3:0] REG_DST_BASE = 4'h3;
    localparam logic [3:0] REG_DST_OFS  = 4'h4;
    localparam logic [3:0] REG_CONST    = 4'h5;
    localparam logic [3:0] REG_STATUS   = 4'h6;
    localparam logic [3:0] REG_INT_STAT = 4'h7;
    localparam logic [3:0] REG_INT_MASK = 4'h8;
    // field positions and codes
    localparam int CTRL_OPC_LSB = 0;
    localparam int CTRL_DT_LSB  = 2;
    localparam int CTRL_SOP_BIT = 4;
    localparam int CTRL_DOP_BIT = 5;
    localparam int OPD_DEV_LSB  = 16;
    localparam int OPD_REP_LSB  = 24;
    localparam int ST_BUSY_BIT  = 0;
    localparam int ST_ERR_BIT   = 1;
    localparam int INT_DONE_BIT = 0;
    localparam int INT_ERR_BIT  = 1;
    localparam logic [1:0] OPC_COPY_INV  = 2'h0;
    localparam logic [1:0] OPC_ICOPY     = 2'h1;
    localparam logic [1:0] OPC_ICOPY_INV = 2'h2;
    localparam logic [1:0] DT_WORD  = 2'h0;
    localparam logic [1:0] DT_DWORD = 2'h1;
    localparam logic [1:0] DT_FLOAT = 2'h2;
    localparam logic [5:0]  RST_CTRL = 6'h00;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [1:0]  RST_INT  = 2'h0;

    typedef struct packed {
        logic [6:0]  rep;
        logic [3:0]  dev;
        logic [15:0] index;
    } iwm_operand_type;

    typedef struct packed {
        logic        rd;
        logic        wr;
        logic        preset;
        logic [3:0]  dev;
        logic [15:0] addr;
        logic [15:0] wdata;
    } iwm_mem_req_type;

    function automatic logic is_bit_dev(input logic [3:0] d);
        is_bit_dev = (d <= DEV_SHIFT) || (d == DEV_SPECIAL);
    endfunction : is_bit_dev

    function automatic logic [15:0] dev_limit(input logic [3:0] d);
        case (d)
            DEV_IN, DEV_OUT: dev_limit = MAX_IO;
            DEV_RELAY:       dev_limit = MAX_RELAY;
            DEV_DATA:        dev_limit = MAX_DATA;
            default:         dev_limit = MAX_SMALL;
        endcase
    endfunction : dev_limit

    // repeat 0 means no repeat
    function automatic logic [6:0] rep1(input logic [6:0] r);
        rep1 = (r == 7'h00) ? 7'h01 : r;
    endfunction : rep1

    // which half of the 32-bit value a transfer carries
    function automatic logic upper_half(input logic h, input logic bitdev,
                                        input logic dword);
        upper_half = dword && (bitdev ? h : !h);
    endfunction : upper_half

    function automatic logic float_normal(input logic [31:0] v);
        float_normal = ((v[30:23] != 8'h00) && (v[30:23] != 8'hff)) ||
                       (v[30:0] == 31'h0000_0000);
    endfunction : float_normal
endpackage : iwm_pkg

// effective address former and range check for one base operand
module iwm_addr_chk (
    // operand
    input  wire logic [3:0]  dev,
    input  wire logic [15:0] base,
    input  wire logic [15:0] ofs,
    input  wire logic [6:0]  step,
    input  wire logic        dword,
    // result
    output logic      [15:0] eff,
    output logic             ok
);
    logic [18:0] unit;
    logic [18:0] sum;
    logic [18:0] last;

    // bit devices move 16 or 32 points, word devices 1 or 2 per element
    always_comb begin
        if (iwm_pkg::is_bit_dev(dev)) begin
            unit = dword ? 19'h00020 : 19'h00010;
        end else begin
            unit = dword ? 19'h00002 : 19'h00001;
        end
        sum  = {3'h0, base} + {3'h0, ofs} + 19'(step) * unit;
        last = sum + unit - 19'h00001;
        eff  = sum[15:0];
        ok   = (dev == iwm_pkg::DEV_CONST) ||
               ((dev < iwm_pkg::DEV_CONST) &&
                (last <= {3'h0, iwm_pkg::dev_limit(dev)}));
    end
endmodule : iwm_addr_chk

`default_nettype wire

/* bench/iwm_move_unit_tb.sv */
// self-checking bench of the indirect word move unit
// assumes the unit's own assertions; the bench stands in for device memory
`default_nettype none
module iwm_move_unit_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic                     mclk = 1'b0, rst_b = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0;
    logic                     exec_en = 1'b0, scan_pulse = 1'b0, ovr = 1'b0, wp;
    logic [3:0]               reg_addr = 4'h0;
    logic [31:0]              reg_wdata = 32'h0, reg_rdata, cv = 32'h0, v, lw;
    logic [15:0]              mem_rdata = 16'h0, wa, wd, sb, db, k1, k2;
    logic [5:0]               c;
    logic                     exec_error_flag, err_led, busy, irq;
    iwm_pkg::iwm_mem_req_type mem;
    int                       fails = 0, n_checks = 0, nw = 0;

    iwm_move_unit dut_u (.mclk(mclk), .rst_b(rst_b), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .exec_en(exec_en), .scan_pulse(scan_pulse), .mem(mem), .mem_rdata(mem_rdata),
        .exec_error_flag(exec_error_flag), .err_led(err_led), .busy(busy), .irq(irq));

    always #2 mclk = ~mclk;

    // offsets sit at data 0x700 up and read as their low nibble
    function automatic logic [15:0] rdv(input logic [15:0] a);
        rdv = (a[15:8] == 8'h07) ? {12'h000, a[3:0]} : ovr ? 16'h7f80 : a ^ 16'h5a3c;
    endfunction : rdv

    function automatic logic [31:0] opd(input logic [3:0] d, input logic [15:0] i);
        opd = {12'h000, d, i};
    endfunction : opd

    // memory answers a read one cycle later; between reads the bus toggles
    always @(posedge mclk) begin
        mem_rdata <= mem.rd ? rdv(mem.addr) : ~mem_rdata;
        if (mem.wr && nw == 0) begin
            wa <= mem.addr;
            wd <= mem.wdata;
            wp <= mem.preset;
        end
        if (mem.wr) begin
            nw <= nw + 1;
            lw <= {mem.addr, mem.wdata};
        end
    end

    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic report_and_stop();
        if (fails == 0 && n_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : report_and_stop

    // strobes drop with an idle edge after, so no task reassigns in one step
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge mclk);
        reg_wr <= 1'b0;
        @(posedge mclk);
    endtask : wr

    task automatic rd(input logic [3:0] a, output logic [31:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge mclk);
        reg_rd <= 1'b0;
        @(posedge mclk);
        d = reg_rdata;
    endtask : rd

    task automatic run(input logic [5:0] cc, input logic [31:0] s, so, d, dof, input logic en);
        int t;
        wr(iwm_pkg::REG_CTRL, {26'h0, cc});
        wr(iwm_pkg::REG_SRC_BASE, s);
        wr(iwm_pkg::REG_SRC_OFS, so);
        wr(iwm_pkg::REG_DST_BASE, d);
        wr(iwm_pkg::REG_DST_OFS, dof);
        wr(iwm_pkg::REG_CONST, cv);
        nw <= 0;
        exec_en <= en;
        scan_pulse <= 1'b1;
        @(posedge mclk);
        scan_pulse <= 1'b0;
        t = 0;
        do begin
            @(posedge mclk);
            t++;
        end while (busy !== 1'b0 && t < 300);
        @(posedge mclk);
        if (t >= 300) begin
            fails++;
            report_and_stop();
        end
    endtask : run

    // reset, random indirect moves, corner cases, error cases
    initial begin
        void'($urandom(49));
        repeat (2) @(posedge mclk);
        rst_b <= 1'b1;
        repeat (3) @(posedge mclk);
        rd(4'hf, v);
        chk("unmapped", v, 32'h0);
        wr(iwm_pkg::REG_INT_MASK, 32'h2);
        for (int i = 0; i < 16; i++) begin
            sb = 16'($urandom_range(0, 239));
            db = 16'($urandom_range(0, 239));
            k1 = 16'($urandom_range(0, 15));
            k2 = 16'($urandom_range(0, 15));
            c = {i[3:2], iwm_pkg::DT_WORD, i[0] ? iwm_pkg::OPC_ICOPY_INV : iwm_pkg::OPC_ICOPY};
            run(c, opd(iwm_pkg::DEV_DATA, sb), opd(iwm_pkg::DEV_DATA, 16'h0700 + k1),
                opd(i[1] ? iwm_pkg::DEV_TIMER : iwm_pkg::DEV_DATA, db),
                opd(iwm_pkg::DEV_DATA, 16'h0700 + k2), 1'b1);
            chk("writes", 32'(nw), 32'h1);
            chk("dst", {16'h0, wa}, {16'h0, db + (i[3] ? k2 : 16'h0)});
            chk("data", {16'h0, wd}, {16'h0, rdv(sb + (i[2] ? k1 : 16'h0)) ^ {16{i[0]}}});
            chk("preset", {31'h0, wp}, {31'h0, i[1]});
        end
        cv = $urandom();
        run(6'h00, opd(iwm_pkg::DEV_CONST, 16'h0), 0, opd(iwm_pkg::DEV_DATA, db), 0, 1'b1);
        chk("const", {16'h0, wd}, {16'h0, ~cv[15:0]});
        run({2'b00, iwm_pkg::DT_DWORD, iwm_pkg::OPC_ICOPY}, opd(iwm_pkg::DEV_DATA, sb), 0,
            opd(iwm_pkg::DEV_DATA, db), 0, 1'b1);
        chk("dw_count", 32'(nw), 32'h2);
        chk("dw_upper", {wa, wd}, {db, rdv(sb)});
        // repeat 2 on both bases, relay destination steps by 16 bits
        v = 32'h0200_0000;
        c = {2'b00, iwm_pkg::DT_WORD, iwm_pkg::OPC_ICOPY};
        run(c, opd(iwm_pkg::DEV_DATA, sb) | v, 0, opd(iwm_pkg::DEV_RELAY, db) | v, 0, 1'b1);
        chk("rep_count", 32'(nw), 32'h2);
        chk("rep_first", {wa, wd}, {db, rdv(sb)});
        chk("rep_last", lw, {db + 16'h0010, rdv(sb + 16'h0001)});
        run(6'h01, opd(iwm_pkg::DEV_DATA, sb), 0, opd(iwm_pkg::DEV_DATA, db), 0, 1'b0);
        chk("disabled", 32'(nw), 32'h0);
        rd(iwm_pkg::REG_INT_STAT, v);
        chk("done_int", v, 32'h1);
        // range, special relay, float device, abnormal float, inverted float, repeat 100
        for (int j = 0; j < 6; j++) begin
            ovr = (j == 3);
            c = {2'b10, (j > 1 && j < 5) ? iwm_pkg::DT_FLOAT : iwm_pkg::DT_WORD,
                 j == 4 ? iwm_pkg::OPC_ICOPY_INV : iwm_pkg::OPC_ICOPY};
            run(c, opd(j == 2 ? iwm_pkg::DEV_TIMER : iwm_pkg::DEV_DATA, 16'h0010) |
                (j == 5 ? 32'h6400_0000 : 32'h0000_0000), 0,
                opd(j == 1 ? iwm_pkg::DEV_SPECIAL : iwm_pkg::DEV_DATA, j ? 16'h0020 : 16'h07ff),
                opd(iwm_pkg::DEV_DATA, 16'h0701), 1'b1);
            chk("err_writes", 32'(nw), 32'h0);
            chk("err_out", {29'h0, exec_error_flag, err_led, irq}, 32'h7);
            rd(iwm_pkg::REG_STATUS, v);
            chk("status", v, 32'h2);
            wr(iwm_pkg::REG_STATUS, 32'h2);
            wr(iwm_pkg::REG_INT_STAT, 32'h3);
            chk("cleared", {30'h0, exec_error_flag, irq}, 32'h0);
        end
        report_and_stop();
    end
endmodule : iwm_move_unit_tb
`default_nettype wire
